// ===== shared/bcid_defs.svh
// Constants for the banked configuration index/data block.
`ifndef BCID_DEFS_SVH
`define BCID_DEFS_SVH
// ****************************************************************
// Port addresses
// ****************************************************************
`define BCID_BASE_LO       16'h002E
`define BCID_BASE_HI       16'h004E
`define BCID_DATA_OFS      16'h0001
// ****************************************************************
// Configuration indexes and read values
// ****************************************************************
`define BCID_IDX_RST       8'h00
`define BCID_IDX_BANKSEL   8'h07
`define BCID_IDX_GLB_FIRST 8'h20
`define BCID_IDX_GLB_LAST  8'h2F
`define BCID_IDX_ACT       8'h30
`define BCID_IDX_DMA0      8'h74
`define BCID_IDX_DMA1      8'h75
`define BCID_RD_UNIMP      8'h00
`define BCID_RD_NODMA      8'h04
`define BCID_BANK_RST      8'h00
`define BCID_GLB_RST       8'h00
`define BCID_ACT_BIT       0
`define BCID_NUM_BANKS     11
`define BCID_NUM_GLB       16
// ****************************************************************
// Link nibble codes and phase lengths
// ****************************************************************
`define BCID_LAD_START     4'h0
`define BCID_LAD_SYNC      4'h0
`define BCID_LAD_TAR       4'hF
`define BCID_CYC_IORD      3'h0
`define BCID_CYC_IOWR      3'h1
`define BCID_ADDR_LAST     2'h3
`define BCID_PAIR_LAST     2'h1
`endif

// ===== shared/bcid_pkg.sv
// Types shared by the banked configuration index/data block.
package bcid_pkg;
   // ****************************************************************
   // Link cycle engine states
   // ****************************************************************
   typedef enum logic [2:0] {
      LpcIdle, LpcCyc, LpcAddr, LpcWdata,
      LpcTarHost, LpcSync, LpcRdata, LpcTarDev
   } bcid_lpc_state_t;
   // ****************************************************************
   // Internal 8-bit bus carriers and link pin drive
   // ****************************************************************
   typedef struct packed {
      logic        strobe;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bcid_io_req_t;
   typedef struct packed {
      logic       claim;
      logic [7:0] rdata;
   } bcid_io_ans_t;
   typedef struct packed {
      logic [3:0] data;
      logic       oe;
   } bcid_lad_drv_t;
endpackage

// ===== sim/bcid_chk.sv
// Port-level assertions for the configuration block's top module.
`timescale 1ns/100ps
`include "bcid_defs.svh"
module bcid_chk
   import bcid_pkg::*;
#(
   parameter int NUM_BANKS = `BCID_NUM_BANKS
)(
   input wire logic                          clk_sys,
   input wire logic                          nrst,
   input wire logic                          base_address_strap,
   input wire logic                          lpcFrameN,
   input wire logic [3:0]                    lpcAdIn,
   input wire logic [3:0]                    lpcAdOut,
   input wire logic                          lpcAdOe,
   input wire bcid_io_req_t                  intReq,
   input wire bcid_io_ans_t                  intAns,
   input wire logic [NUM_BANKS-1:0]          devActive,
   input wire logic [`BCID_NUM_GLB-1:0][7:0] globalCfg,
   input wire logic [7:0]                    bankSel,
   input wire logic                          baseHigh
);
   // ********
   // Checks
   // ********
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [15:0] baseW;
   assign baseW = baseHigh ? `BCID_BASE_HI : `BCID_BASE_LO;
   sequence syncNib;
      lpcAdOe && lpcAdOut == `BCID_LAD_SYNC;
   endsequence
   sequence quietLink;
      !lpcAdOe [*4];
   endsequence
   strap_capture_a:
      assert property ($rose(nrst) |=> baseHigh == $past(base_address_strap))
      else $error("Strap level not captured after reset.");
   reset_values_a:
      assert property ($rose(nrst) |-> bankSel == 8'h00 && !lpcAdOe)
      else $error("Registers not at reset value after reset.");
   claim_sync_a:
      assert property (intReq.strobe && intAns.claim |-> ##2 syncNib)
      else $error("Claimed transfer not answered on time.");
   unclaimed_quiet_a:
      assert property (intReq.strobe && !intAns.claim |=> quietLink)
      else $error("Link driven for an unclaimed address.");
   pair_private_a:
      assert property (intReq.strobe |-> intReq.addr != baseW &&
                       intReq.addr != baseW + 16'h0001)
      else $error("Config port leaked to the internal bus.");
   strobe_pulse_a:
      assert property (intReq.strobe |=> !intReq.strobe)
      else $error("Internal strobe longer than one cycle.");
   bank_guard_a:
      assert property ($changed(devActive) |-> $past(bankSel) < NUM_BANKS
                       && $onehot(devActive ^ $past(devActive)))
      else $error("Activation changed outside the selected bank.");
   write_sync_a:
      assert property ($changed(bankSel) || $changed(globalCfg) |->
                       ##[0:2] syncNib)
      else $error("Register changed without a link write.");
   tar_end_a:
      assert property ($fell(lpcAdOe) |-> $past(lpcAdOut) == `BCID_LAD_TAR)
      else $error("Link released without a turnaround nibble.");
endmodule
bind bcid_config_top bcid_chk #(.NUM_BANKS(NUM_BANKS)) bcid_chk_inst (
   .clk_sys(clk_sys), .nrst(nrst), .base_address_strap(base_address_strap),
   .lpcFrameN(lpcFrameN), .lpcAdIn(lpcAdIn), .lpcAdOut(lpcAdOut),
   .lpcAdOe(lpcAdOe), .intReq(intReq), .intAns(intAns),
   .devActive(devActive), .globalCfg(globalCfg), .bankSel(bankSel),
   .baseHigh(baseHigh));

// ===== sim/bcid_lpc_host.sv
// Behavioural link host that issues byte I/O cycles.
`timescale 1ns/100ps
`include "bcid_defs.svh"
module bcid_lpc_host (
   input  wire logic       clk_sys,
   input  wire logic [3:0] lpcAdOut,
   input  wire logic       lpcAdOe,
   output logic            lpcFrameN,
   output logic [3:0]      lpcAdIn
);
   logic       hostOe;
   logic [3:0] hostNib;
   // Set by a scenario to send a memory cycle, which no target may claim.
   logic       cycMem;
   // Released lines are pulled up, so a floating nibble reads all ones.
   assign lpcAdIn = hostOe ? hostNib : (lpcAdOe ? lpcAdOut : 4'hF);
   initial begin
      lpcFrameN = 1'b1;
      hostOe = 1'b0;
      hostNib = 4'hF;
      cycMem = 1'b0;
   end
   task automatic nib(input logic f, input logic [3:0] v);
      @(posedge clk_sys);
      lpcFrameN <= f;
      hostOe <= 1'b1;
      hostNib <= v;
   endtask
   task automatic io(input logic wr, input logic [15:0] a,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic ok);
      ok = 1'b0;
      rd = 8'h00;
      nib(1'b0, `BCID_LAD_START);
      nib(1'b1, {1'b0, cycMem, wr, 1'b0});
      for (int i = 3; i >= 0; i--) nib(1'b1, a[i*4 +: 4]);
      if (wr) begin
         nib(1'b1, wd[3:0]);
         nib(1'b1, wd[7:4]);
      end
      nib(1'b1, `BCID_LAD_TAR);
      @(posedge clk_sys);
      hostOe <= 1'b0;
      // A missing answer is given up after six cycles, as a host would.
      for (int i = 0; i < 6 && !ok; i++) begin
         @(posedge clk_sys);
         ok = lpcAdOe && lpcAdIn === `BCID_LAD_SYNC;
      end
      if (ok && !wr) begin
         @(posedge clk_sys);
         rd[3:0] = lpcAdIn;
         @(posedge clk_sys);
         rd[7:4] = lpcAdIn;
      end
   endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench for the banked configuration index/data block.
`timescale 1ns/100ps
`include "bcid_defs.svh"
module tb
   import bcid_pkg::*;
;
   localparam logic [15:0] BLK_ADDR = 16'h0080;
   logic                          clk_sys;
   logic                          nrst;
   logic                          base_address_strap;
   logic                          lpcFrameN;
   logic [3:0]                    lpcAdIn;
   logic [3:0]                    lpcAdOut;
   logic                          lpcAdOe;
   bcid_io_req_t                  intReq;
   bcid_io_ans_t                  intAns;
   logic [`BCID_NUM_BANKS-1:0]    devActive;
   logic [`BCID_NUM_GLB-1:0][7:0] globalCfg;
   logic [7:0]                    bankSel;
   logic                          baseHigh;
   logic [15:0]                   base;
   bcid_io_req_t                  lastReq;
   int                            nFail;
   int                            nChecks;
   int                            cycles;
   // ********
   // Environment
   // ********
   // One internal function answers at a single address, combinationally.
   assign intAns = '{claim: intReq.strobe && intReq.addr == BLK_ADDR,
                     rdata: 8'hA5};
   // The last internal request is kept so a scenario can judge it later.
   always @(posedge clk_sys) begin
      if (intReq.strobe) begin
         lastReq <= intReq;
      end
   end
   always #2.5 clk_sys = ~clk_sys;
   bcid_config_top #(.NUM_BANKS(`BCID_NUM_BANKS)) bcid_config_top_inst (
      .clk_sys(clk_sys), .nrst(nrst), .base_address_strap(base_address_strap),
      .lpcFrameN(lpcFrameN), .lpcAdIn(lpcAdIn), .lpcAdOut(lpcAdOut),
      .lpcAdOe(lpcAdOe), .intReq(intReq), .intAns(intAns),
      .devActive(devActive), .globalCfg(globalCfg), .bankSel(bankSel),
      .baseHigh(baseHigh));
   bcid_lpc_host bcid_lpc_host_inst (
      .clk_sys(clk_sys), .lpcAdOut(lpcAdOut), .lpcAdOe(lpcAdOe),
      .lpcFrameN(lpcFrameN), .lpcAdIn(lpcAdIn));
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         nFail++;
         giveVerdict();
      end
   end
   // ********
   // Helpers
   // ********
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      nChecks++;
      if (got !== exp) begin
         nFail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] r,
                       input logic expOk);
      logic ok;
      bcid_lpc_host_inst.io(w, a, d, r, ok);
      check("answer", {15'h0000, expOk}, {15'h0000, ok});
   endtask
   task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] r;
      xfer(1'b1, base, i, r, 1'b1);
      xfer(1'b1, base + 16'h0001, d, r, 1'b1);
   endtask
   task automatic cfg_chk(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] r;
      xfer(1'b1, base, i, r, 1'b1);
      xfer(1'b0, base + 16'h0001, 8'h00, r, 1'b1);
      check("config read", {8'h00, e}, {8'h00, r});
   endtask
   task automatic do_reset(input logic s);
      nrst <= 1'b0;
      base_address_strap <= s;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      base = s ? `BCID_BASE_HI : `BCID_BASE_LO;
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_index();
      logic [7:0] r;
      xfer(1'b0, base, 8'h00, r, 1'b1);
      check("index reset", 16'h0000, {8'h00, r});
      xfer(1'b1, base, 8'h5A, r, 1'b1);
      xfer(1'b0, base, 8'h00, r, 1'b1);
      check("index", 16'h005A, {8'h00, r});
   endtask
   task automatic t_banks();
      logic [7:0]  r;
      logic [10:0] exp;
      exp = 11'h000;
      for (int b = 0; b < 12; b++) begin
         cfg_wr(`BCID_IDX_BANKSEL, b[7:0]);
         cfg_chk(`BCID_IDX_BANKSEL, b[7:0]);
         cfg_chk(`BCID_IDX_ACT, 8'h00);
         // Reserved bits are written as zero, the value they read back above.
         xfer(1'b1, base + 16'h0001, {7'h00, !b[0]}, r, 1'b1);
         if (b < 11) exp[b] = !b[0];
      end
      check("active", {5'h00, exp}, {5'h00, devActive});
      for (int b = 0; b < 12; b++) begin
         cfg_wr(`BCID_IDX_BANKSEL, b[7:0]);
         cfg_chk(`BCID_IDX_ACT, {7'h00, b < 11 && !b[0]});
      end
   endtask
   task automatic t_global();
      cfg_wr(`BCID_IDX_BANKSEL, 8'h03);
      cfg_wr(`BCID_IDX_GLB_FIRST, 8'hC3);
      cfg_wr(`BCID_IDX_GLB_LAST, 8'h3C);
      cfg_wr(`BCID_IDX_BANKSEL, 8'h09);
      cfg_chk(`BCID_IDX_GLB_FIRST, 8'hC3);
      cfg_chk(`BCID_IDX_GLB_LAST, 8'h3C);
      check("global", 16'h3CC3, {globalCfg[15], globalCfg[0]});
      check("bank", 16'h0009, {8'h00, bankSel});
   endtask
   task automatic t_unimp();
      cfg_wr(8'h40, 8'h77);
      cfg_chk(8'h40, `BCID_RD_UNIMP);
      cfg_chk(8'h1F, `BCID_RD_UNIMP);
      cfg_wr(`BCID_IDX_DMA0, 8'h01);
      cfg_chk(`BCID_IDX_DMA0, `BCID_RD_NODMA);
      cfg_chk(`BCID_IDX_DMA1, `BCID_RD_NODMA);
   endtask
   task automatic t_link();
      logic [7:0] r;
      xfer(1'b0, BLK_ADDR, 8'h00, r, 1'b1);
      check("internal read", 16'h00A5, {8'h00, r});
      xfer(1'b1, BLK_ADDR, 8'h3C, r, 1'b1);
      check("internal write", {8'h01, 8'h3C},
            {7'h00, lastReq.write, lastReq.wdata});
      check("internal addr", BLK_ADDR, lastReq.addr);
      xfer(1'b0, BLK_ADDR + 16'h0001, 8'h00, r, 1'b0);
      bcid_lpc_host_inst.cycMem = 1'b1;
      xfer(1'b0, base, 8'h00, r, 1'b0);
      bcid_lpc_host_inst.cycMem = 1'b0;
      do_reset(1'b1);
      xfer(1'b0, `BCID_BASE_LO, 8'h00, r, 1'b0);
      check("strap", 16'h0001, {15'h0000, baseHigh});
      xfer(1'b0, 16'h014E, 8'h00, r, 1'b0);
      t_index();
      cfg_chk(`BCID_IDX_BANKSEL, `BCID_BANK_RST);
   endtask
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", nChecks, nFail);
      if (nFail == 0 && nChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      nrst = 1'b0;
      base_address_strap = 1'b0;
      base = `BCID_BASE_LO;
      nFail = 0;
      nChecks = 0;
      cycles = 0;
      do_reset(1'b0);
      t_index();
      t_banks();
      t_global();
      t_unimp();
      t_link();
      giveVerdict();
   end
endmodule

// ===== src/bcid_cfg_regs.sv
// Index pointer, bank selector, global and banked configuration registers.
`timescale 1ns/100ps
`include "bcid_defs.svh"
module bcid_cfg_regs
   import bcid_pkg::*;
#(
   parameter int NUM_BANKS = `BCID_NUM_BANKS
)(
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire bcid_io_req_t          cfgReq,
   input  wire logic                  selData,
   output logic [7:0]                 cfgRdata,
   output logic [NUM_BANKS-1:0]       devActive,
   output logic [`BCID_NUM_GLB-1:0][7:0] globalCfg,
   output logic [7:0]                 bankSel
);
   logic [7:0]                 index_r;
   logic [7:0]                 bankSel_r;
   logic [`BCID_NUM_GLB-1:0][7:0] glb_r;
   logic [NUM_BANKS-1:0]       act_r;
   wire  logic                 wrIndex;
   wire  logic                 wrData;
   wire  logic                 bankOk;
   wire  logic                 inGlb;
   wire  logic                 isAct;

   // ****************************************************************
   // Decode
   // ****************************************************************
   assign wrIndex = cfgReq.strobe && cfgReq.write && !selData;
   assign wrData  = cfgReq.strobe && cfgReq.write && selData; // RQ4
   assign bankOk  = bankSel_r < 8'(NUM_BANKS); // RQ7
   assign inGlb   = index_r >= `BCID_IDX_GLB_FIRST &&
                    index_r <= `BCID_IDX_GLB_LAST; // RQ16
   assign isAct   = index_r == `BCID_IDX_ACT;

   // A reserved bank number reaches no bank at all, so it reads as empty.
   function automatic logic [7:0] cfgRead(input logic [7:0] idx);
      if (idx == `BCID_IDX_BANKSEL) begin
         return bankSel_r; // RQ7
      end else if (idx >= `BCID_IDX_GLB_FIRST &&
                   idx <= `BCID_IDX_GLB_LAST) begin
         return glb_r[idx[3:0]]; // RQ6
      end else if (idx == `BCID_IDX_ACT && bankOk) begin
         return {7'h00, act_r[bankSel_r[3:0]]}; // RQ15
      end else if (idx == `BCID_IDX_DMA0 || idx == `BCID_IDX_DMA1) begin
         return `BCID_RD_NODMA; // RQ10
      end else begin
         return `BCID_RD_UNIMP; // RQ9
      end
   endfunction

   assign cfgRdata  = selData ? cfgRead(index_r) : index_r; // RQ3
   assign devActive = act_r; // RQ18
   assign globalCfg = glb_r;
   assign bankSel   = bankSel_r;

   // ****************************************************************
   // Storage
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         index_r   <= `BCID_IDX_RST; // RQ3
         bankSel_r <= `BCID_BANK_RST;
         glb_r     <= '0;
         act_r     <= '0;
      end else begin
         if (wrIndex) begin
            index_r <= cfgReq.wdata; // RQ2
         end
         if (wrData && index_r == `BCID_IDX_BANKSEL) begin
            bankSel_r <= cfgReq.wdata; // RQ7
         end
         if (wrData && inGlb) begin
            glb_r[index_r[3:0]] <= cfgReq.wdata; // RQ6 RQ12
         end
         if (wrData && isAct && bankOk) begin
            act_r[bankSel_r[3:0]] <= cfgReq.wdata[`BCID_ACT_BIT]; // RQ5 RQ8
         end
      end
   end
endmodule

// ===== src/bcid_config_top.sv
// Link target, port decode and internal bus bridge of the config block.
`timescale 1ns/100ps
`include "bcid_defs.svh"
// Overview of operation
// RQ1 - Strap at reset picks base 2Eh or 4Eh.
// RQ2 - Index port is 8-bit pointer at base.
// RQ3 - Index reads last written value, else 00h.
// RQ4 - Data port forwards to indexed register.
// RQ5 - Index 30h and up reaches selected bank; here only 30h is banked, higher indexes act as unimplemented.
// RQ6 - Global registers shared, independent of bank.
// RQ7 - Bank selector at 07h; above 0Ah reserved.
// RQ8 - Eleven banks, one per logical device.
// RQ9 - Unimplemented: writes ignored, reads 00h.
// RQ10 - Unimplemented 74h and 75h read 04h.
// RQ11 - Access works right after reset ends.
// RQ12 - Registers read/write; reserved bits read zero.
// RQ13 - Host preserves reserved bits by read-modify-write.
// RQ14 - Host writes write-only registers directly.
// RQ15 - Bank register 30h bit 0 activates device.
// RQ16 - Indexes 20h to 2Fh are global registers.
// RQ17 - Link byte I/O cycles become internal bus transfers.
// RQ18 - Central set drives settings to each block.
// RQ19 - Activation enables device and its resources.
// RQ20 - Data at base plus one; full address match.
module bcid_config_top
   import bcid_pkg::*;
#(
   parameter int NUM_BANKS = `BCID_NUM_BANKS
)(
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic                  base_address_strap,
   input  wire logic                  lpcFrameN,
   input  wire logic [3:0]            lpcAdIn,
   output logic [3:0]                 lpcAdOut,
   output logic                       lpcAdOe,
   output bcid_io_req_t               intReq,
   input  wire bcid_io_ans_t          intAns,
   output logic [NUM_BANKS-1:0]       devActive,
   output logic [`BCID_NUM_GLB-1:0][7:0] globalCfg,
   output logic [7:0]                 bankSel,
   output logic                       baseHigh
);
   bcid_lpc_state_t state_r;
   bcid_lpc_state_t state_nxt;
   logic [1:0]      cnt_r;
   logic [1:0]      cnt_nxt;
   logic            write_r;
   logic [15:0]     addr_r;
   logic [7:0]      wdata_r;
   logic [7:0]      rdata_r;
   logic            claim_r;
   bcid_lad_drv_t   lad_r;
   bcid_lad_drv_t   lad_nxt;
   logic            strapDone_r;
   logic            baseHi_r;
   wire  logic      startSeen;
   wire  logic      frameAbort;
   wire  logic      cycKnown;
   wire  logic      reqStrobe;
   wire  logic [15:0] portBase;
   wire  logic      hitIndex;
   wire  logic      hitData;
   wire  logic      cfgHit;
   wire  logic [7:0] cfgRdata;
   bcid_io_req_t    cfgReq;
   bcid_io_ans_t    ans;

   // ****************************************************************
   // Base address strap
   // ****************************************************************
   // The strap is caught on the first edge after reset release, which is
   // long before any cycle can finish its address phase.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         strapDone_r <= 1'b0;
         baseHi_r    <= 1'b0;
      end else if (!strapDone_r) begin
         strapDone_r <= 1'b1;
         baseHi_r    <= base_address_strap; // RQ1
      end
   end

   assign baseHigh = baseHi_r;
   assign portBase = baseHi_r ? `BCID_BASE_HI : `BCID_BASE_LO; // RQ1

   // ****************************************************************
   // Cycle framing
   // ****************************************************************
   assign startSeen  = !lpcFrameN && lpcAdIn == `BCID_LAD_START;
   assign frameAbort = !lpcFrameN && !startSeen;
   assign cycKnown   = lpcAdIn[3:1] == `BCID_CYC_IORD ||
                       lpcAdIn[3:1] == `BCID_CYC_IOWR; // RQ17
   // Other cycle types, DMA included, are left for the block that owns
   // the channel; this target never answers them.

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r + 2'h1;
      unique case (state_r)
         LpcIdle: begin
            cnt_nxt = 2'h0;
         end
         LpcCyc: begin
            cnt_nxt   = 2'h0;
            state_nxt = cycKnown ? LpcAddr : LpcIdle;
         end
         LpcAddr: begin
            if (cnt_r == `BCID_ADDR_LAST) begin
               cnt_nxt   = 2'h0;
               state_nxt = write_r ? LpcWdata : LpcTarHost;
            end
         end
         LpcWdata: begin
            if (cnt_r == `BCID_PAIR_LAST) begin
               cnt_nxt   = 2'h0;
               state_nxt = LpcTarHost;
            end
         end
         LpcTarHost: begin
            if (cnt_r == `BCID_PAIR_LAST) begin
               cnt_nxt   = 2'h0;
               state_nxt = claim_r ? LpcSync : LpcIdle;
            end
         end
         LpcSync: begin
            cnt_nxt   = 2'h0;
            state_nxt = write_r ? LpcTarDev : LpcRdata;
         end
         LpcRdata: begin
            if (cnt_r == `BCID_PAIR_LAST) begin
               cnt_nxt   = 2'h0;
               state_nxt = LpcTarDev;
            end
         end
         LpcTarDev: begin
            if (cnt_r == `BCID_PAIR_LAST) begin
               cnt_nxt   = 2'h0;
               state_nxt = LpcIdle;
            end
         end
      endcase
      if (startSeen) begin
         state_nxt = LpcCyc;
         cnt_nxt   = 2'h0;
      end else if (frameAbort) begin
         state_nxt = LpcIdle;
         cnt_nxt   = 2'h0;
      end
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   // Drive is planned from the next state so the pins leave a flop in
   // step with the state they belong to.
   function automatic bcid_lad_drv_t ladDrive(
      input bcid_lpc_state_t st,
      input logic [1:0]      cnt,
      input logic [7:0]      rd
   );
      bcid_lad_drv_t d;
      d = '{data: `BCID_LAD_TAR, oe: 1'b0};
      unique case (st)
         LpcSync: begin
            d = '{data: `BCID_LAD_SYNC, oe: 1'b1};
         end
         LpcRdata: begin
            d = '{data: (cnt == 2'h0) ? rd[3:0] : rd[7:4], oe: 1'b1};
         end
         LpcTarDev: begin
            d = '{data: `BCID_LAD_TAR, oe: cnt == 2'h0};
         end
         default: begin
            d = '{data: `BCID_LAD_TAR, oe: 1'b0};
         end
      endcase
      return d;
   endfunction

   assign lad_nxt  = ladDrive(state_nxt, cnt_nxt, rdata_r);
   assign lpcAdOut = lad_r.data;
   assign lpcAdOe  = lad_r.oe;

   // ****************************************************************
   // Engine registers
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r <= LpcIdle;
         cnt_r   <= 2'h0;
         lad_r   <= '{data: `BCID_LAD_TAR, oe: 1'b0};
      end else begin
         state_r <= state_nxt; // RQ11
         cnt_r   <= cnt_nxt;
         lad_r   <= lad_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         write_r <= 1'b0;
         addr_r  <= 16'h0000;
         wdata_r <= 8'h00;
      end else begin
         if (state_r == LpcCyc) begin
            write_r <= lpcAdIn[1];
         end
         if (state_r == LpcAddr) begin
            addr_r <= {addr_r[11:0], lpcAdIn}; // RQ20
         end
         if (state_r == LpcWdata && cnt_r == 2'h0) begin
            wdata_r[3:0] <= lpcAdIn;
         end
         if (state_r == LpcWdata && cnt_r == `BCID_PAIR_LAST) begin
            wdata_r[7:4] <= lpcAdIn;
         end
      end
   end

   // The answer is caught in the same edge as the request, so every
   // internal block must answer combinationally within one cycle.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         claim_r <= 1'b0;
         rdata_r <= 8'h00;
      end else if (reqStrobe) begin
         claim_r <= ans.claim;
         rdata_r <= ans.rdata;
      end else if (state_r == LpcIdle) begin
         claim_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Port decode and internal bus
   // ****************************************************************
   assign reqStrobe = state_r == LpcTarHost && cnt_r == 2'h0 &&
                      lpcFrameN; // RQ17
   assign hitIndex  = addr_r == portBase; // RQ2 RQ20
   assign hitData   = addr_r == portBase + `BCID_DATA_OFS; // RQ20
   assign cfgHit    = hitIndex || hitData;

   assign cfgReq = '{strobe: reqStrobe && cfgHit, write: write_r,
                     addr: addr_r, wdata: wdata_r};
   assign intReq = '{strobe: reqStrobe && !cfgHit, write: write_r,
                     addr: addr_r, wdata: wdata_r}; // RQ17
   assign ans    = '{claim: cfgHit || intAns.claim,
                     rdata: cfgHit ? cfgRdata : intAns.rdata};

   // ****************************************************************
   // Configuration register set
   // ****************************************************************
   // Activation bits leave here as the enables of the functional blocks;
   // a block whose bit is clear must ignore its resources.
   bcid_cfg_regs #(
      .NUM_BANKS (NUM_BANKS)
   ) u_regs (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .cfgReq    (cfgReq),
      .selData   (hitData),
      .cfgRdata  (cfgRdata),
      .devActive (devActive), // RQ19
      .globalCfg (globalCfg),
      .bankSel   (bankSel)
   );
endmodule
